// File: cfgerr_pkg.sv
// Purpose: shared constants and types of the error report block
// Assumes: 32-bit avalon-mm register bus, byte addresses
// Notes:   timing counts derive from the clock rate below
package cfgerr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_ERROR    = 8'h08;
    localparam logic [7:0] OFS_CTRL     = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    // error_report field positions
    localparam int ERR_CARD_RESET  = 0;
    localparam int ERR_CARD_READY  = 1;
    localparam int ERR_CARD_READ   = 2;
    localparam int ERR_CARD_WRITE  = 3;
    localparam int ERR_SECTOR      = 4;
    localparam int ERR_IMAGE_ADDR  = 5;
    localparam int ERR_CHAIN       = 6;
    localparam int ERR_FETCH       = 7;
    localparam int ERR_INSTR       = 8;
    localparam int ERR_INIT        = 9;
    localparam int ERR_CTRL_BITS   = 10;
    localparam int ERR_CARD_LSB    = 11;
    // card error byte positions (bad block, uncorr, idnf, abort, amnf)
    localparam int CARD_BBK  = 7;
    localparam int CARD_UNC  = 6;
    localparam int CARD_IDNF = 4;
    localparam int CARD_ABRT = 2;
    localparam int CARD_AMNF = 0;
    // status and control field positions
    localparam int STAT_MON_BUSY   = 0;
    localparam int STAT_CARD_ERR   = 23;
    localparam int CTRL_FORCE_ADDR = 0;
    localparam int CTRL_ADDR_LSB   = 16;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    // timing
    localparam longint CLK_HZ          = 100_000_000;
    localparam longint INIT_TIMEOUT_MS = 500;
    localparam longint INIT_TIMEOUT_CYC = INIT_TIMEOUT_MS * CLK_HZ / 1000;

    // kind of card read command that failed
    typedef enum logic [1:0] {
        RD_NONE     = 2'b00,
        RD_SECTOR   = 2'b01,
        RD_IDENTIFY = 2'b10
    } cfgerr_rdcmd_t;

    // init monitor states
    typedef enum logic [1:0] {
        MON_IDLE = 2'b00,
        MON_WAIT = 2'b01,
        MON_DONE = 2'b10
    } cfgerr_mon_t;

    // failure pulses from the card and chain sequencers
    typedef struct packed {
        logic          card_reset_to;
        logic          card_ready_to;
        logic          card_read_fail;
        cfgerr_rdcmd_t read_kind;
        logic          card_write_fail;
        logic          sector_to;
        logic          chain_fail;
        logic          fetch_fail;
        logic          bad_instr;
    } cfgerr_evt_t;

    // operation start pulses, each clears its own flags
    typedef struct packed {
        logic card_reset;
        logic card_ready;
        logic card_read;
        logic card_write;
        logic sector;
        logic config_run;
    } cfgerr_start_t;
endpackage

// File: cfgerr_top.sv
// Purpose: error report register bank of a card-to-chain config controller
// Assumes: sequencer pulses are synchronous to clk_sys
//          card error byte and status bit are levels
// Notes:   avalon-mm slave, one wait cycle per access
//          interrupt status is a separate w1c copy of flags 0..9;
//          error flags themselves clear only on reset or a new start
`timescale 1ns/1ps
`default_nettype none
module cfgerr_top
    import cfgerr_pkg::*;
#(
    parameter longint INIT_CYC = INIT_TIMEOUT_CYC,
    parameter int     IMG_W    = 16
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // sequencer events
    input  wire cfgerr_evt_t   evt,
    input  wire cfgerr_start_t op_start,
    // configuration side
    input  wire logic [1:0]  image_addr_pins,
    input  wire logic [IMG_W-1:0] image_count,
    input  wire logic        target_init_sense,
    // card task-file state
    input  wire logic [7:0]  card_err_byte,
    input  wire logic        card_status_err,
    // control out and interrupt
    output logic             use_register_image_address,
    output logic [IMG_W-1:0] image_select_address,
    output logic             irq
);

    // refuse widths the logic cannot serve; the control field is 16 wide
    if (IMG_W != 16)
    begin : g_bad_width
        $error("image address width must be 16");
    end

    // the monitor counter is 32 bits, so longer timeouts cannot be counted
    if (INIT_CYC < 1 || INIT_CYC > 64'h0000_0000_ffff_ffff)
    begin : g_bad_init
        $error("init timeout count out of range");
    end

    // offset match, shared by read and write decode
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // byte lane mask from byte enables
    function automatic logic [31:0] lanes(input logic [3:0] be);
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // sticky error flags and interrupt state
    logic [ERR_CTRL_BITS-1:0] err_ff;
    logic [ERR_CTRL_BITS-1:0] nxt_err;
    logic [ERR_CTRL_BITS-1:0] irq_stat_ff;
    logic [ERR_CTRL_BITS-1:0] nxt_irq_stat;
    logic [ERR_CTRL_BITS-1:0] irq_mask_ff;
    logic [ERR_CTRL_BITS-1:0] nxt_irq_mask;
    logic                     irq_ff;

    // card mirrors, one cycle behind the card inputs
    logic [7:0]               card_err_ff;
    logic                     card_stat_ff;

    // control fields written by software
    logic                     force_ff;
    logic                     nxt_force;
    logic [IMG_W-1:0]         img_addr_ff;
    logic [IMG_W-1:0]         nxt_img_addr;

    // bus answer
    logic                     wait_ff;
    logic                     nxt_wait;
    logic [31:0]              rdata_ff;
    logic [31:0]              nxt_rdata;
    logic [31:0]              rd_mux;

    // init monitor
    cfgerr_mon_t              mon_ff;
    cfgerr_mon_t              nxt_mon;
    logic [31:0]              mon_cnt_ff;
    logic [31:0]              nxt_mon_cnt;

    // bus handshake decode
    wire logic        req      = avs_read | avs_write;
    wire logic        accept   = req & wait_ff;
    wire logic        wr_en    = avs_write & ~wait_ff;

    // write lanes and register selects; writes land only in the answer cycle
    wire logic [31:0] wmask    = lanes(avs_byteenable);
    wire logic [31:0] wbits    = avs_writedata & wmask;
    wire logic        wr_ctrl  = wr_en & hit(avs_address, OFS_CTRL);
    wire logic        wr_istat = wr_en & hit(avs_address, OFS_IRQ_STAT);
    wire logic        wr_imask = wr_en & hit(avs_address, OFS_IRQ_MASK);

    // read fail counts only for the two card read commands
    wire logic rd_kind_ok = (evt.read_kind == RD_SECTOR)
                          | (evt.read_kind == RD_IDENTIFY);

    // image address chosen by the force bit
    wire logic [IMG_W-1:0] sel_addr = force_ff ? img_addr_ff
                         : {{(IMG_W-2){1'b0}}, image_addr_pins};
    wire logic addr_bad = op_start.config_run
                        & (sel_addr >= image_count);

    // init monitor expiry; comparing against INIT_CYC - 1 makes the flag
    // land exactly INIT_CYC edges after the start pulse
    wire logic mon_expire = (mon_ff == MON_WAIT)
                          & (mon_cnt_ff == 32'(INIT_CYC - 1))
                          & ~target_init_sense;

    // flag set sources, one per controller bit
    wire logic [ERR_CTRL_BITS-1:0] set_vec;
    assign set_vec[ERR_CARD_RESET] = evt.card_reset_to;
    assign set_vec[ERR_CARD_READY] = evt.card_ready_to;
    assign set_vec[ERR_CARD_READ]  = evt.card_read_fail
                                   & rd_kind_ok;
    assign set_vec[ERR_CARD_WRITE] = evt.card_write_fail;
    assign set_vec[ERR_SECTOR]     = evt.sector_to;

    // configuration side failures
    assign set_vec[ERR_IMAGE_ADDR] = addr_bad;
    assign set_vec[ERR_CHAIN]      = evt.chain_fail;
    assign set_vec[ERR_FETCH]      = evt.fetch_fail;
    assign set_vec[ERR_INSTR]      = evt.bad_instr;
    assign set_vec[ERR_INIT]       = mon_expire;

    // flag clear sources: a new run of the same kind
    wire logic [ERR_CTRL_BITS-1:0] clr_vec;
    assign clr_vec[ERR_CARD_RESET] = op_start.card_reset;
    assign clr_vec[ERR_CARD_READY] = op_start.card_ready;
    assign clr_vec[ERR_CARD_READ]  = op_start.card_read;
    assign clr_vec[ERR_CARD_WRITE] = op_start.card_write;
    assign clr_vec[ERR_SECTOR]     = op_start.sector;

    // one config run restarts every configuration flag
    assign clr_vec[ERR_IMAGE_ADDR] = op_start.config_run;
    assign clr_vec[ERR_CHAIN]      = op_start.config_run;
    assign clr_vec[ERR_FETCH]      = op_start.config_run;
    assign clr_vec[ERR_INSTR]      = op_start.config_run;
    assign clr_vec[ERR_INIT]       = op_start.config_run;

    // sticky flags; a set in the clearing cycle wins
    // so a failure in the start cycle is never lost
    genvar gi;
    generate
        for (gi = 0; gi < ERR_CTRL_BITS; gi++)
        begin : g_flag
            assign nxt_err[gi] = set_vec[gi]
                               | (err_ff[gi] & ~clr_vec[gi]);
            assign nxt_irq_stat[gi] = set_vec[gi]
                | (irq_stat_ff[gi] & ~(wr_istat & wbits[gi]));
        end
    endgenerate

    // mask and control writes honour byte lanes
    assign nxt_irq_mask = wr_imask
        ? (irq_mask_ff & ~wmask[ERR_CTRL_BITS-1:0])
          | wbits[ERR_CTRL_BITS-1:0]
        : irq_mask_ff;
    assign nxt_force = wr_ctrl & wmask[CTRL_FORCE_ADDR]
                     ? avs_writedata[CTRL_FORCE_ADDR] : force_ff;
    assign nxt_img_addr = wr_ctrl
        ? (img_addr_ff & ~wmask[CTRL_ADDR_LSB +: IMG_W])
          | wbits[CTRL_ADDR_LSB +: IMG_W]
        : img_addr_ff;

    // error word as seen by software; bit 10 and top half stay zero
    wire logic [31:0] err_word = {16'h0000,
        card_err_ff[CARD_AMNF],
        card_err_ff[CARD_ABRT],
        card_err_ff[CARD_IDNF],
        card_err_ff[CARD_UNC],
        card_err_ff[CARD_BBK],
        1'b0,
        err_ff};

    // status word: card error and monitor activity
    wire logic [31:0] stat_word =
        (32'(card_stat_ff) << STAT_CARD_ERR)
      | (32'(mon_ff == MON_WAIT) << STAT_MON_BUSY);

    wire logic [31:0] ctrl_word =
        (32'(img_addr_ff) << CTRL_ADDR_LSB)
      | (32'(force_ff) << CTRL_FORCE_ADDR);

    // read mux; unmapped offsets answer zero
    always_comb
    begin
        if (hit(avs_address, OFS_ERROR))
            rd_mux = err_word;
        else if (hit(avs_address, OFS_STATUS))
            rd_mux = stat_word;
        else if (hit(avs_address, OFS_CTRL))
            rd_mux = ctrl_word;
        else if (hit(avs_address, OFS_IRQ_STAT))
            rd_mux = 32'(irq_stat_ff);
        else if (hit(avs_address, OFS_IRQ_MASK))
            rd_mux = 32'(irq_mask_ff);
        else
            rd_mux = RST_ZERO;
    end

    // one wait cycle, then a single low cycle per access
    // read data is latched at acceptance so it stands through the answer
    assign nxt_wait  = ~accept;
    assign nxt_rdata = (accept & avs_read) ? rd_mux : rdata_ff;

    // init monitor: counts from config start until sense rises or the count expires
    always_comb
    begin
        nxt_mon     = mon_ff;
        nxt_mon_cnt = mon_cnt_ff;
        case (mon_ff)
            MON_IDLE:
            begin
                if (op_start.config_run)
                begin
                    nxt_mon     = MON_WAIT;
                    nxt_mon_cnt = 32'h0000_0000;
                end
            end
            MON_WAIT:
            begin
                // a new start restarts the count from zero
                if (op_start.config_run)
                    nxt_mon_cnt = 32'h0000_0000;
                else if (target_init_sense)
                    nxt_mon = MON_DONE;
                else if (mon_expire)
                    nxt_mon = MON_DONE;
                else
                    nxt_mon_cnt = mon_cnt_ff + 32'h0000_0001;
            end
            MON_DONE:
            begin
                if (op_start.config_run)
                begin
                    nxt_mon     = MON_WAIT;
                    nxt_mon_cnt = 32'h0000_0000;
                end
            end
            default:
                nxt_mon = MON_IDLE;
        endcase
    end

    // flag and interrupt state
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            err_ff      <= RST_ZERO[ERR_CTRL_BITS-1:0];
            irq_stat_ff <= RST_ZERO[ERR_CTRL_BITS-1:0];
            irq_mask_ff <= RST_ZERO[ERR_CTRL_BITS-1:0];
            irq_ff      <= 1'b0;
        end
        else
        begin
            err_ff      <= nxt_err;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff      <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // mirrored card state, sampled each cycle
    // the card byte is a level, so no capture strobe is needed
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            card_err_ff  <= RST_ZERO[7:0];
            card_stat_ff <= 1'b0;
        end
        else
        begin
            card_err_ff  <= card_err_byte;
            card_stat_ff <= card_status_err;
        end
    end

    // control fields; reset leaves the address pins in charge
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            force_ff    <= 1'b0;
            img_addr_ff <= RST_ADDR;
        end
        else
        begin
            force_ff    <= nxt_force;
            img_addr_ff <= nxt_img_addr;
        end
    end

    // init monitor state
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mon_ff     <= MON_IDLE;
            mon_cnt_ff <= RST_ZERO;
        end
        else
        begin
            mon_ff     <= nxt_mon;
            mon_cnt_ff <= nxt_mon_cnt;
        end
    end

    // bus answer; wait stays high when idle so no edge is missed
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= RST_ZERO;
        end
        else
        begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs straight from flops
    assign avs_waitrequest            = wait_ff;
    assign avs_readdata               = rdata_ff;

    // interrupt and control outputs
    assign irq                        = irq_ff;
    assign use_register_image_address = force_ff;
    assign image_select_address       = img_addr_ff;

endmodule
`default_nettype wire

// File: cfgerr_top_monitor.sv
// Purpose: concurrent checks on the error report bank ports
// Assumes: single clock domain, one wait cycle per bus access
// Notes:   card mirrors checked only once the inputs have settled
`timescale 1ns/1ps
`default_nettype none
module cfgerr_top_monitor
    import cfgerr_pkg::*;
#(
    parameter int IMG_W = 16
)(
    // clock and reset
    input wire logic             clk_sys,
    input wire logic             sys_rst,
    // register bus
    input wire logic [7:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    // card and control side
    input wire logic [7:0]       card_err_byte,
    input wire logic             card_status_err,
    input wire logic             use_register_image_address,
    input wire logic [IMG_W-1:0] image_select_address,
    input wire logic             irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // completed accesses by word offset
    wire       rd_done = avs_read && !avs_waitrequest;
    wire       wr_done = avs_write && !avs_waitrequest;
    wire [5:0] wa      = avs_address[7:2];
    wire       rd_err  = rd_done && wa == 6'h02;
    // one-cycle copies so stability can be judged without slicing $past
    logic [7:0] cb_ff;
    logic       st_ff;
    always_ff @(posedge clk_sys)
    begin
        cb_ff <= card_err_byte;
        st_ff <= card_status_err;
    end
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer in the cycle after a request");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_err_reserved: assert property (rd_err |-> avs_readdata[31:16] == 16'h0000 && !avs_readdata[10])
        else $error("reserved error bits not zero");
    a_card_mirror: assert property (rd_err && cb_ff == $past(cb_ff, 1) && cb_ff == $past(cb_ff, 2)
        |-> avs_readdata[15:11] == {cb_ff[0], cb_ff[2], cb_ff[4], cb_ff[6], cb_ff[7]})
        else $error("card error bits do not follow the card");
    a_status_mirror: assert property (rd_done && wa == 6'h01 && st_ff == $past(st_ff, 1)
        && st_ff == $past(st_ff, 2) |-> avs_readdata[23] == st_ff)
        else $error("status card error flag does not follow the card");
    a_unmapped_zero: assert property (rd_done && !(wa inside {6'h01, 6'h02, 6'h06, 6'h08, 6'h09})
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped offset read not zero");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr_done, 1) || $past(wr_done, 2))
        else $error("irq dropped without a register write");
    a_ctrl_write: assert property (wr_done && wa == 6'h06 && avs_byteenable == 4'hf
        |=> {image_select_address, 15'h0000, use_register_image_address}
            == ($past(avs_writedata) & 32'hffff_0001))
        else $error("control outputs do not follow the write");
endmodule
bind cfgerr_top cfgerr_top_monitor #(.IMG_W(IMG_W)) u_mon (.clk_sys, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .card_err_byte, .card_status_err, .use_register_image_address, .image_select_address, .irq);
`default_nettype wire

// File: cfgerr_host_model.sv
// Purpose: host processor model speaking avalon-mm to the bank
// Assumes: one request at a time, full-word byte enables
// Notes:   waits for the slave without limit; the bench timeout ends a hang
`timescale 1ns/1ps
`default_nettype none
module cfgerr_host_model (
    // bus answer
    input  wire logic        clk_sys,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    // bus request
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable
);
    // idle bus from time zero
    initial
    begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hf;
    end
    // request held until waitrequest is sampled low, data taken at that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: cfgerr_top_tb.sv
// Purpose: self-checking bench of the error report bank
// Assumes: init timeout shortened to INIT_N cycles
// Notes:   expected flags tracked in exp_err as events are raised
`timescale 1ns/1ps
`default_nettype none
module cfgerr_top_tb;
    import cfgerr_pkg::*;
    localparam longint INIT_N = 20;
    // clock, reset, bus
    logic          clk_sys;
    logic          sys_rst;
    logic [7:0]    avs_address;
    logic          avs_read;
    logic          avs_write;
    logic [31:0]   avs_writedata;
    logic [3:0]    avs_byteenable;
    logic [31:0]   avs_readdata;
    logic          avs_waitrequest;
    // sequencer, card and outputs
    cfgerr_evt_t   evt;
    cfgerr_start_t op_start;
    logic [1:0]    image_addr_pins;
    logic [15:0]   image_count;
    logic          target_init_sense;
    logic [7:0]    card_err_byte;
    logic          card_status_err;
    logic          use_register_image_address;
    logic [15:0]   image_select_address;
    logic          irq;
    // bookkeeping and tables
    int            err_total;
    int            tests_run;
    int            cycles = 0;
    logic [31:0]   exp_err;
    logic [31:0]   q;
    logic [31:0]   ctrl_seen;
    assign ctrl_seen = {image_select_address, 15'h0000, use_register_image_address};
    logic [9:0]    ev_code [8] = '{10'h200, 10'h100, 10'h0a0, 10'h010,
                                   10'h008, 10'h004, 10'h002, 10'h001};
    int            ev_bit [8] = '{0, 1, 2, 3, 4, 6, 7, 8};
    int            cb_pos [5] = '{7, 6, 4, 2, 0};

    cfgerr_top #(.INIT_CYC(INIT_N), .IMG_W(16)) dut (.clk_sys, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .evt, .op_start, .image_addr_pins, .image_count,
        .target_init_sense, .card_err_byte, .card_status_err,
        .use_register_image_address, .image_select_address, .irq);
    cfgerr_host_model host (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable);

    // 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        $display("tests_run %0d err_total %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        host.xfer(1'b1, a, d, unused);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one-cycle pulses on the sequencer inputs
    task automatic fire(input logic [9:0] c);
        @(posedge clk_sys);
        evt <= c;
        @(posedge clk_sys);
        evt <= '0;
    endtask
    task automatic go(input cfgerr_start_t s);
        @(posedge clk_sys);
        op_start <= s;
        @(posedge clk_sys);
        op_start <= '0;
    endtask

    task automatic t_reset();
        rd(OFS_ERROR);
        check("error_report", 32'h0000_0000, q);
        wr(OFS_ERROR, 32'hffff_ffff);
        rd(OFS_ERROR);
        check("error_report ro", 32'h0000_0000, q);
        rd(8'h30);
        check("unmapped", 32'h0000_0000, q);
        $display("test reset done");
    endtask
    task automatic t_events();
        exp_err = 32'h0000_0000;
        fire(10'h080);
        rd(OFS_ERROR);
        check("no read kind", exp_err, q);
        for (int i = 0; i < 8; i++)
        begin
            fire(ev_code[i]);
            exp_err[ev_bit[i]] = 1'b1;
            rd(OFS_ERROR);
            check("event flag", exp_err, q);
        end
        go('{card_reset: 1'b1, card_read: 1'b1, default: 1'b0});
        exp_err[2:0] = 3'b010;
        rd(OFS_ERROR);
        check("start clears", exp_err, q);
        fire(10'h0c0);
        exp_err[2] = 1'b1;
        rd(OFS_ERROR);
        check("identify fail", exp_err, q);
        $display("test events done");
    endtask
    task automatic t_addr_init();
        target_init_sense <= 1'b0;
        wr(OFS_CTRL, 32'h0002_0001);
        go('{config_run: 1'b1, default: 1'b0});
        check("control outputs", 32'h0002_0001, ctrl_seen);
        exp_err[9:5] = 5'b00001;
        rd(OFS_ERROR);
        check("address equals count", exp_err, q);
        idle(INIT_N);
        exp_err[9] = 1'b1;
        rd(OFS_ERROR);
        check("init timeout", exp_err, q);
        wr(OFS_CTRL, 32'h0000_0000);
        image_addr_pins <= 2'b01;
        target_init_sense <= 1'b1;
        go('{config_run: 1'b1, default: 1'b0});
        check("control cleared", 32'h0000_0000, ctrl_seen);
        exp_err[9:5] = 5'b00000;
        idle(INIT_N + 4);
        rd(OFS_ERROR);
        check("pins address valid", exp_err, q);
        $display("test address and init done");
    endtask
    task automatic t_mirror();
        for (int i = 0; i < 5; i++)
        begin
            card_err_byte <= 8'h01 << cb_pos[i];
            card_status_err <= i[0];
            idle(3);
            rd(OFS_ERROR);
            check("card mirror", exp_err | (32'h0000_0800 << i), q);
            rd(OFS_STATUS);
            check("card error status", {31'h0, i[0]}, {31'h0, q[23]});
        end
        card_err_byte <= 8'h00;
        $display("test mirror done");
    endtask
    task automatic t_irq();
        wr(OFS_IRQ_STAT, 32'h0000_03ff);
        wr(OFS_IRQ_MASK, 32'h0000_0040);
        idle(3);
        check("irq idle", 32'h0, {31'h0, irq});
        fire(10'h004);
        idle(2);
        check("irq raised", 32'h1, {31'h0, irq});
        fire(10'h002);
        wr(OFS_IRQ_STAT, 32'h0000_0040);
        idle(3);
        check("irq cleared", 32'h0, {31'h0, irq});
        rd(OFS_IRQ_STAT);
        check("irq status", 32'h0000_0080, q);
        $display("test irq done");
    endtask
    task automatic t_midrst();
        fire(10'h001);
        rd(OFS_ERROR);
        check("flag before reset", 32'h0000_0100, q & 32'h0000_0100);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        rd(OFS_ERROR);
        check("flags after reset", 32'h0000_0000, q);
        $display("test mid reset done");
    endtask

    // main sequence
    initial
    begin
        err_total = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        evt = '0;
        op_start = '0;
        image_addr_pins = 2'b00;
        image_count = 16'h0002;
        target_init_sense = 1'b1;
        card_err_byte = 8'h00;
        card_status_err = 1'b0;
        idle(2);
        sys_rst <= 1'b0;
        idle(3);
        t_reset();
        t_events();
        t_addr_init();
        t_mirror();
        t_irq();
        t_midrst();
        final_report();
    end
endmodule
`default_nettype wire
